// File: inc/ftc_defs.svh
`ifndef FTC_DEFS_SVH
`define FTC_DEFS_SVH

// ********************************************************************
// Register offsets (byte addresses).
// ********************************************************************
`define FTC_OFS_CTRL 5'h00
`define FTC_OFS_BURST 5'h04
`define FTC_OFS_DELAY 5'h08
`define FTC_OFS_HEIGHT 5'h0c
`define FTC_OFS_CMD 5'h10
`define FTC_OFS_STATUS 5'h14
`define FTC_OFS_PIN 5'h18

// ********************************************************************
// Control word fields.
// ********************************************************************
`define FTC_CTRL_KIND 0
`define FTC_CTRL_EN_LO 1
`define FTC_CTRL_EN_HI 2
`define FTC_CTRL_SRC_LO 3
`define FTC_CTRL_SRC_HI 4
`define FTC_CTRL_COND_LO 5
`define FTC_CTRL_COND_HI 7
`define FTC_CTRL_POL_LO 8
`define FTC_CTRL_POL_HI 9
`define FTC_CTRL_SYNC 10
`define FTC_CMD_FIRE 0
`define FTC_PIN_CHOICE 0
`define FTC_PIN_FLIP 1

// ********************************************************************
// Reset values and timing.
// ********************************************************************
`define FTC_BURST_RST 16'h0001
`define FTC_HEIGHT_RST 16'h0400
`define FTC_DELAY_MAX_US 21'h1e8480
`define FTC_CLK_NS 40
`define FTC_TICK_NS 1000
`define FTC_US_CYCLES (`FTC_TICK_NS / `FTC_CLK_NS)

`endif

// File: inc/ftc_pkg.sv
package ftc_pkg;
  typedef enum logic [3:0] {
    FTC_IDLE = 4'h1,
    FTC_DELAY = 4'h2,
    FTC_ISSUE = 4'h4,
    FTC_RUN = 4'h8
  } ftc_state_e;
  typedef enum logic [1:0] {
    FTC_SRC_CC1 = 2'h0,
    FTC_SRC_SOFT = 2'h1,
    FTC_SRC_TIMER = 2'h2,
    FTC_SRC_COUNTER = 2'h3
  } ftc_src_e;
  typedef enum logic [2:0] {
    FTC_RISE = 3'h0,
    FTC_FALL = 3'h1,
    FTC_ANY = 3'h2,
    FTC_LVL_HI = 3'h3,
    FTC_LVL_LO = 3'h4
  } ftc_cond_e;
  typedef enum logic [1:0] {
    FTC_OVL_OFF = 2'h0,
    FTC_OVL_READOUT = 2'h1,
    FTC_OVL_AFTER_EXP = 2'h2
  } ftc_policy_e;
endpackage

// File: design/ftc_top.sv
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "ftc_defs.svh"

module ftc_top
  import ftc_pkg::*;
#(
  parameter int BURST_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cc1,
  input wire logic cc2,
  input wire logic timer_one_done,
  input wire logic counter_one_done,
  input wire logic exposure_active,
  input wire logic readout_active,
  input wire logic exposure_fits,
  output logic frame_start,
  output logic [15:0] frame_rows,
  output logic invalid_fire,
  output logic fire_busy
);

  localparam int US_CYCLES = `FTC_US_CYCLES;

  // ******************************************************************
  // Avalon-MM slave.
  // ******************************************************************
  // A request is answered one cycle after it is taken; waitrequest is low
  // for exactly that cycle, which is also when a write lands.
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_take;
  logic rd_take;
  logic [31:0] rd_mux;

  logic fire_kind_select_q;
  logic [1:0] fire_enable_state_q;
  ftc_src_e fire_origin_select_q;
  ftc_cond_e fire_condition_q;
  ftc_policy_e fire_accept_policy_q;
  logic sync_align_q;
  logic [BURST_W-1:0] burst_frames_total_q;
  logic [20:0] fire_postpone_us_q;
  logic [15:0] height_q;
  logic pin_choice_q;
  logic [1:0] pin_polarity_flip_q;
  logic soft_fire_command_q;
  logic [7:0] invalid_cnt_q;
  ftc_state_e state_q;
  ftc_state_e state_d;
  logic [BURST_W-1:0] remain_q;

  assign wr_take = avs_write && !wait_q;
  assign rd_take = avs_read && wait_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      `FTC_OFS_CTRL: begin
        rd_mux[`FTC_CTRL_KIND] = fire_kind_select_q;
        rd_mux[`FTC_CTRL_EN_HI:`FTC_CTRL_EN_LO] = fire_enable_state_q;
        rd_mux[`FTC_CTRL_SRC_HI:`FTC_CTRL_SRC_LO] = fire_origin_select_q;
        rd_mux[`FTC_CTRL_COND_HI:`FTC_CTRL_COND_LO] = fire_condition_q;
        rd_mux[`FTC_CTRL_POL_HI:`FTC_CTRL_POL_LO] = fire_accept_policy_q;
        rd_mux[`FTC_CTRL_SYNC] = sync_align_q;
      end
      `FTC_OFS_BURST: rd_mux[BURST_W-1:0] = burst_frames_total_q;
      `FTC_OFS_DELAY: rd_mux[20:0] = fire_postpone_us_q;
      `FTC_OFS_HEIGHT: rd_mux[15:0] = height_q;
      `FTC_OFS_STATUS: rd_mux = {invalid_cnt_q, remain_q[BURST_W-1:0], 2'h0, cc2, cc1, state_q};
      `FTC_OFS_PIN: begin
        rd_mux[`FTC_PIN_CHOICE] = pin_choice_q;
        rd_mux[`FTC_PIN_FLIP] = pin_polarity_flip_q[pin_choice_q];
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ******************************************************************
  // Configuration registers.
  // ******************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      fire_kind_select_q <= 1'b0;
      fire_enable_state_q <= 2'h0;
      fire_origin_select_q <= FTC_SRC_CC1;
      fire_condition_q <= FTC_RISE;
      fire_accept_policy_q <= FTC_OVL_OFF;
      sync_align_q <= 1'b0;
      burst_frames_total_q <= BURST_W'(`FTC_BURST_RST);
      fire_postpone_us_q <= 21'h0;
      height_q <= `FTC_HEIGHT_RST;
      pin_choice_q <= 1'b0;
      pin_polarity_flip_q <= 2'h0;
    end else if (wr_take) begin
      case (avs_address)
        `FTC_OFS_CTRL: begin
          fire_kind_select_q <= avs_writedata[`FTC_CTRL_KIND];
          fire_enable_state_q <= avs_writedata[`FTC_CTRL_EN_HI:`FTC_CTRL_EN_LO];
          fire_origin_select_q <= ftc_src_e'(avs_writedata[`FTC_CTRL_SRC_HI:`FTC_CTRL_SRC_LO]);
          fire_condition_q <= ftc_cond_e'(avs_writedata[`FTC_CTRL_COND_HI:`FTC_CTRL_COND_LO]);
          fire_accept_policy_q <= ftc_policy_e'(avs_writedata[`FTC_CTRL_POL_HI:`FTC_CTRL_POL_LO]);
          sync_align_q <= avs_writedata[`FTC_CTRL_SYNC];
        end
        `FTC_OFS_BURST: burst_frames_total_q <= avs_writedata[BURST_W-1:0];
        `FTC_OFS_DELAY: begin
          // Values past the documented maximum are clamped rather than wrapped.
          if (avs_writedata[20:0] > `FTC_DELAY_MAX_US || avs_writedata[31:21] != 11'h0) begin
            fire_postpone_us_q <= `FTC_DELAY_MAX_US;
          end else begin
            fire_postpone_us_q <= avs_writedata[20:0];
          end
        end
        `FTC_OFS_HEIGHT: height_q <= avs_writedata[15:0];
        `FTC_OFS_PIN: begin
          pin_choice_q <= avs_writedata[`FTC_PIN_CHOICE];
          pin_polarity_flip_q[avs_writedata[`FTC_PIN_CHOICE]] <= avs_writedata[`FTC_PIN_FLIP];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      soft_fire_command_q <= 1'b0;
    end else begin
      soft_fire_command_q <= wr_take && avs_address == `FTC_OFS_CMD && avs_writedata[`FTC_CMD_FIRE];
    end
  end

  // ******************************************************************
  // Trigger qualification.
  // ******************************************************************
  logic line_c;
  logic line_prev_q;
  logic line_hit;
  logic hw_fire;
  logic en_act;
  logic raw_fire;
  logic accept_ok;
  logic start_ok;

  // Inputs are synchronous, so the edge detector samples the pin directly.
  // A pulse shorter than one clock can be missed entirely.
  assign line_c = cc1 ^ pin_polarity_flip_q[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      line_prev_q <= 1'b0;
    end else begin
      line_prev_q <= line_c;
    end
  end

  always_comb begin
    case (fire_condition_q)
      FTC_RISE: line_hit = line_c && !line_prev_q;
      FTC_FALL: line_hit = !line_c && line_prev_q;
      FTC_ANY: line_hit = line_c != line_prev_q;
      FTC_LVL_HI: line_hit = line_c;
      FTC_LVL_LO: line_hit = !line_c;
      default: line_hit = 1'b0;
    endcase
  end

  // The condition only shapes the line path; internal events pass untouched.
  always_comb begin
    case (fire_origin_select_q)
      FTC_SRC_CC1: hw_fire = line_hit;
      FTC_SRC_SOFT: hw_fire = 1'b0;
      FTC_SRC_TIMER: hw_fire = timer_one_done;
      FTC_SRC_COUNTER: hw_fire = counter_one_done;
      default: hw_fire = 1'b0;
    endcase
  end

  assign en_act = fire_enable_state_q[fire_kind_select_q];
  assign raw_fire = en_act && (hw_fire || soft_fire_command_q);

  always_comb begin
    case (fire_accept_policy_q)
      FTC_OVL_OFF: begin
        accept_ok = !exposure_active && !readout_active;
        start_ok = accept_ok;
      end
      FTC_OVL_READOUT: begin
        accept_ok = !exposure_active;
        start_ok = !exposure_active;
      end
      FTC_OVL_AFTER_EXP: begin
        accept_ok = !exposure_active;
        start_ok = !exposure_active && (!readout_active || exposure_fits);
      end
      default: begin
        accept_ok = 1'b0;
        start_ok = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // Delay, frame issue and burst sequencing.
  // ******************************************************************
  logic take_fire;
  logic [4:0] us_cnt_q;
  logic us_tick;
  logic [20:0] delay_cnt_q;
  logic frame_start_q;
  logic invalid_q;
  logic [15:0] rows_q;

  assign take_fire = state_q == FTC_IDLE && raw_fire && accept_ok;
  assign us_tick = us_cnt_q == 5'(US_CYCLES - 1);

  // The prescaler restarts on each accepted trigger so the delay is exact.
  always_ff @(posedge mclk) begin
    if (rst || take_fire || us_tick) begin
      us_cnt_q <= 5'h0;
    end else begin
      us_cnt_q <= us_cnt_q + 5'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      FTC_IDLE: begin
        if (take_fire) begin
          state_d = (fire_postpone_us_q == 21'h0) ? FTC_ISSUE : FTC_DELAY;
        end
      end
      FTC_DELAY: begin
        if (us_tick && delay_cnt_q == 21'h1) begin
          state_d = FTC_ISSUE;
        end
      end
      FTC_ISSUE: begin
        if (start_ok) begin
          state_d = FTC_RUN;
        end
      end
      FTC_RUN: begin
        if (exposure_active) begin
          state_d = (remain_q == '0) ? FTC_IDLE : FTC_ISSUE;
        end
      end
      default: state_d = FTC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= FTC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      delay_cnt_q <= 21'h0;
    end else if (take_fire) begin
      delay_cnt_q <= fire_postpone_us_q;
    end else if (state_q == FTC_DELAY && us_tick) begin
      delay_cnt_q <= delay_cnt_q - 21'h1;
    end
  end

  // A burst count of zero still yields one frame, never a stuck sequence.
  always_ff @(posedge mclk) begin
    if (rst) begin
      remain_q <= '0;
    end else if (take_fire) begin
      if (fire_kind_select_q && burst_frames_total_q != '0) begin
        remain_q <= burst_frames_total_q;
      end else begin
        remain_q <= BURST_W'(1);
      end
    end else if (state_q == FTC_ISSUE && start_ok) begin
      remain_q <= remain_q - BURST_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      frame_start_q <= 1'b0;
      rows_q <= 16'h0;
    end else begin
      frame_start_q <= state_q == FTC_ISSUE && start_ok;
      if (state_q == FTC_ISSUE && start_ok) begin
        rows_q <= height_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      invalid_q <= 1'b0;
      invalid_cnt_q <= 8'h0;
    end else begin
      invalid_q <= raw_fire && sync_align_q && exposure_active;
      if (raw_fire && sync_align_q && exposure_active && invalid_cnt_q != 8'hff) begin
        invalid_cnt_q <= invalid_cnt_q + 8'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fire_busy <= 1'b0;
    end else begin
      fire_busy <= state_d != FTC_IDLE;
    end
  end

  assign frame_start = frame_start_q;
  assign frame_rows = rows_q;
  assign invalid_fire = invalid_q;

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  logic [25:0] dly_cyc_q;
  logic [20:0] dly_ref_q;

  always_ff @(posedge mclk) begin
    if (rst || state_q != FTC_DELAY) begin
      dly_cyc_q <= 26'h0;
    end else begin
      dly_cyc_q <= dly_cyc_q + 26'h1;
    end
    if (rst) begin
      dly_ref_q <= 21'h0;
    end else if (take_fire) begin
      dly_ref_q <= fire_postpone_us_q;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_delay_length: assert property (state_q == FTC_DELAY && state_d == FTC_ISSUE |->
    dly_cyc_q == 26'(dly_ref_q * US_CYCLES - 1)) else $error("delay length wrong");
  a_soft_any_source: assert property (state_q == FTC_IDLE && soft_fire_command_q && en_act && accept_ok
    |=> state_q != FTC_IDLE) else $error("soft fire not taken");
  a_soft_only_src: assert property (state_q == FTC_IDLE && fire_origin_select_q == FTC_SRC_SOFT
    && !soft_fire_command_q |=> state_q == FTC_IDLE) else $error("line fired in software mode");
  a_disabled_holds: assert property (state_q == FTC_IDLE && !en_act |=> state_q == FTC_IDLE)
    else $error("fired while disabled");
  a_rise_edge_fire: assert property (state_q == FTC_IDLE && en_act && accept_ok
    && fire_origin_select_q == FTC_SRC_CC1 && fire_condition_q == FTC_RISE && $rose(line_c)
    |=> state_q != FTC_IDLE) else $error("rising edge missed");
  a_fall_no_rise: assert property (state_q == FTC_IDLE && fire_origin_select_q == FTC_SRC_CC1
    && fire_condition_q == FTC_FALL && !soft_fire_command_q && !$fell(line_c)
    |=> state_q == FTC_IDLE) else $error("fired without falling edge");
  a_timer_fire: assert property (state_q == FTC_IDLE && en_act && accept_ok && timer_one_done
    && fire_origin_select_q == FTC_SRC_TIMER |=> state_q != FTC_IDLE) else $error("timer event missed");
  a_off_policy_block: assert property (state_q == FTC_IDLE && fire_accept_policy_q == FTC_OVL_OFF
    && (exposure_active || readout_active) |=> state_q == FTC_IDLE) else $error("overlap accepted");
  a_after_exp_hold: assert property (state_q == FTC_ISSUE && fire_accept_policy_q == FTC_OVL_AFTER_EXP
    && readout_active && !exposure_fits |=> !frame_start_q) else $error("exposure not postponed");
  a_invalid_flag: assert property (raw_fire && sync_align_q && exposure_active
    |=> invalid_q && (invalid_cnt_q == $past(invalid_cnt_q) + 8'h1 || $past(invalid_cnt_q) == 8'hff))
    else $error("invalid trigger not flagged");
  a_single_rows: assert property (state_q == FTC_ISSUE && start_ok
    |=> frame_start_q && frame_rows == $past(height_q)) else $error("frame start or height wrong");
  a_burst_load: assert property (take_fire && fire_kind_select_q && burst_frames_total_q != '0
    |=> remain_q == $past(burst_frames_total_q)) else $error("burst count not loaded");
  a_wait_answer: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer timing wrong");

  c_burst_run: cover property (take_fire && fire_kind_select_q && burst_frames_total_q > BURST_W'(2));
  c_delayed_fire: cover property (state_q == FTC_DELAY && state_d == FTC_ISSUE);
  c_invalid_seen: cover property (invalid_q);
  c_postponed: cover property (state_q == FTC_ISSUE && readout_active && !start_ok ##1 state_q == FTC_ISSUE && start_ok);

endmodule

// File: dv/ftc_grabber.sv
`timescale 1ns/1ns
// ********************************************************************
// Frame grabber stand-in driving the two camera-control lines.
// ********************************************************************
module ftc_grabber (
  input wire logic mclk,
  input wire logic rst,
  input wire logic want1,
  input wire logic want2,
  output logic cc1,
  output logic cc2
);
  logic line1_q = 1'b0;
  logic line2_q = 1'b0;
  assign cc1 = line1_q;
  assign cc2 = line2_q;
  // Lines move only just after an edge and then hold a whole cycle, so every level is sampled.
  always @(posedge mclk) begin
    if (rst) begin
      line1_q <= 1'b0;
      line2_q <= 1'b0;
    end else begin
      line1_q <= want1;
      line2_q <= want2;
    end
  end
endmodule

// File: dv/ftc_top_test.sv
`timescale 1ns/1ns
`include "ftc_defs.svh"
module ftc_top_test
  import ftc_pkg::*;
();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic cc1;
  logic cc2;
  logic want1 = 1'b0;
  logic tdone = 1'b0;
  logic cdone = 1'b0;
  logic hold_exp = 1'b0;
  logic hold_ro = 1'b0;
  logic fits = 1'b1;
  logic exposure_active;
  logic readout_active;
  logic frame_start;
  logic [15:0] frame_rows;
  logic invalid_fire;
  logic fire_busy;
  logic [31:0] rd;
  int sens = 0;
  int cyc = 0;
  int starts = 0;
  int last_start = 0;
  int bad = 0;
  int errors = 0;
  int check_count = 0;
  int wr_cyc = 0;

  ftc_top u_ftc_top (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cc1(cc1), .cc2(cc2), .timer_one_done(tdone),
    .counter_one_done(cdone), .exposure_active(exposure_active), .readout_active(readout_active),
    .exposure_fits(fits), .frame_start(frame_start), .frame_rows(frame_rows),
    .invalid_fire(invalid_fire), .fire_busy(fire_busy));
  ftc_grabber u_ftc_grabber (.mclk(mclk), .rst(rst), .want1(want1), .want2(1'b0), .cc1(cc1), .cc2(cc2));

  initial begin
    forever #20 mclk = ~mclk;
  end

  // ********************************************************************
  // Sensor stand-in: four cycles of exposure, then readout, per frame.
  // ********************************************************************
  assign exposure_active = hold_exp | (sens >= 1 && sens <= 4);
  assign readout_active = hold_ro | (sens >= 5);
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (invalid_fire === 1'b1) begin
      bad <= bad + 1;
    end
    if (frame_start === 1'b1) begin
      starts <= starts + 1;
      last_start <= cyc;
      sens <= 1;
    end else if (sens > 0 && sens < 11) begin
      sens <= sens + 1;
    end else begin
      sens <= 0;
    end
  end

  // ********************************************************************
  // Shared tasks.
  // ********************************************************************
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    wr_cyc = cyc;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) begin
      errors++;
      give_verdict();
    end
  endtask

  function automatic logic [31:0] ctl(input logic [31:0] kind, en, src, cond, pol, sync);
    return kind | (en << 1) | (src << 3) | (cond << 5) | (pol << 8) | (sync << 10);
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic fire();
    bus(1'b1, `FTC_OFS_CMD, 32'h1);
  endtask

  task automatic pulse(input logic t, input logic c);
    tdone <= t;
    cdone <= c;
    @(posedge mclk);
    tdone <= 1'b0;
    cdone <= 1'b0;
    wait_n(40);
  endtask

  // ********************************************************************
  // Scenarios.
  // ********************************************************************
  task automatic t_regs();
    bus(1'b0, `FTC_OFS_BURST, 32'h0);
    check("burst reset", rd, 32'h1);
    bus(1'b0, `FTC_OFS_HEIGHT, 32'h0);
    check("height reset", rd, 32'h400);
    bus(1'b0, 5'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, `FTC_OFS_CMD, 32'h0);
    check("cmd read", rd, 32'h0);
    bus(1'b1, `FTC_OFS_DELAY, 32'h3fffff);
    bus(1'b0, `FTC_OFS_DELAY, 32'h0);
    check("delay clamp", rd, 32'h1e8480);
    bus(1'b1, `FTC_OFS_DELAY, 32'h0);
    $display("t_regs finished");
  endtask

  task automatic t_soft();
    int s0;
    bus(1'b1, `FTC_OFS_HEIGHT, 32'h20);
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_CC1, FTC_RISE, 0, 0));
    s0 = starts;
    fire();
    wait_n(40);
    check("soft start", 32'(starts - s0), 32'h1);
    check("rows", frame_rows, 32'h20);
    // Only the other kind is enabled, so the selected kind must stay off.
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 2, FTC_SRC_SOFT, FTC_RISE, 0, 0));
    s0 = starts;
    fire();
    wait_n(40);
    check("kind off", 32'(starts - s0), 32'h0);
    check("idle busy", fire_busy, 32'h0);
    $display("t_soft finished");
  endtask

  task automatic t_lines();
    int s0;
    logic pre;
    for (int c = 0; c < 5; c++) begin
      for (int f = 0; f < 2; f++) begin
        pre = f[0] ^ (c == 1 || c == 4);
        bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, c, 0, 0));
        s0 = starts;
        bus(1'b1, `FTC_OFS_PIN, 32'h3);
        bus(1'b1, `FTC_OFS_PIN, 32'(f * 2));
        want1 <= ~pre;
        wait_n(3);
        want1 <= pre;
        wait_n(30);
        bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_CC1, c, 0, 0));
        wait_n(30);
        check("line quiet", 32'(starts - s0), 32'h0);
        want1 <= ~pre;
        wait_n(6);
        want1 <= pre;
        wait_n(40);
        check("line fire", 32'(starts - s0), 32'h1);
      end
    end
    $display("t_lines finished");
  endtask

  task automatic t_srcs();
    int s0;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, k + 2, FTC_LVL_HI, 0, 0));
      s0 = starts;
      pulse(k[0], ~k[0]);
      check("other done", 32'(starts - s0), 32'h0);
      pulse(~k[0], k[0]);
      check("own done", 32'(starts - s0), 32'h1);
    end
    $display("t_srcs finished");
  endtask

  task automatic t_burst();
    int s0;
    bus(1'b1, `FTC_OFS_BURST, 32'h3);
    bus(1'b1, `FTC_OFS_CTRL, ctl(1, 2, FTC_SRC_SOFT, 0, 0, 0));
    s0 = starts;
    fire();
    wait_n(150);
    check("burst", 32'(starts - s0), 32'h3);
    bus(1'b1, `FTC_OFS_BURST, 32'h1);
    $display("t_burst finished");
  endtask

  task automatic t_delay();
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, 0, 0, 0));
    fire();
    wait_n(40);
    check("delay 0", 32'(last_start - wr_cyc), 32'h3);
    bus(1'b1, `FTC_OFS_DELAY, 32'h2);
    fire();
    wait_n(10);
    check("busy in delay", fire_busy, 32'h1);
    wait_n(90);
    check("delay 2", 32'(last_start - wr_cyc), 32'h35);
    bus(1'b1, `FTC_OFS_DELAY, 32'h0);
    $display("t_delay finished");
  endtask

  task automatic t_policy();
    int s0;
    hold_ro <= 1'b1;
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, 0, FTC_OVL_OFF, 0));
    s0 = starts;
    fire();
    wait_n(40);
    check("ovl off", 32'(starts - s0), 32'h0);
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, 0, FTC_OVL_READOUT, 0));
    fire();
    wait_n(40);
    check("ovl readout", 32'(starts - s0), 32'h1);
    hold_ro <= 1'b0;
    hold_exp <= 1'b1;
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, 0, FTC_OVL_AFTER_EXP, 0));
    fire();
    wait_n(40);
    check("in exposure", 32'(starts - s0), 32'h1);
    // A readout still running with a non-fitting exposure must hold the start back.
    hold_exp <= 1'b0;
    hold_ro <= 1'b1;
    fits <= 1'b0;
    fire();
    wait_n(30);
    check("postponed", 32'(starts - s0), 32'h1);
    hold_ro <= 1'b0;
    fits <= 1'b1;
    wait_n(40);
    check("latched", 32'(starts - s0), 32'h2);
    hold_exp <= 1'b1;
    bus(1'b1, `FTC_OFS_CTRL, ctl(0, 1, FTC_SRC_SOFT, 0, FTC_OVL_OFF, 1));
    fire();
    wait_n(40);
    check("sync drop", 32'(starts - s0), 32'h2);
    check("invalid", 32'(bad), 32'h1);
    bus(1'b0, `FTC_OFS_STATUS, 32'h0);
    check("invalid count", {24'h0, rd[31:24]}, 32'h1);
    hold_exp <= 1'b0;
    $display("t_policy finished");
  endtask

  initial begin
    wait_n(2);
    rst <= 1'b0;
    t_regs();
    t_soft();
    t_lines();
    t_srcs();
    t_burst();
    t_delay();
    t_policy();
    give_verdict();
  end
endmodule
